// ===== logic/storage_map.sv
// storage address map: region decode, aux select and trap address forcing
// address map by size (program / control / nothing):
//   16K: 0000-3FFF program, 4000-7FFF control, 8000 up nothing
//   24K: 0000-5FFF program, 6000-7FFF hole, 8000-BFFF control
//   32K: 0000-7FFF program, 8000-BFFF control, C000 up nothing
//   48K: 0000-BFFF program, C000-FFFF control
// aux modules by size: 16K 0-7, 24K 0-5 and 8-B, 32K 0-B, 48K 0-F
//
// the decode works on the value about to be latched, so the selects
// in dec line up with the latch in the same cycle instead of trailing
// it by one; the cost is a longer path from next_addr and the trap
// inputs through the compare chain into the flops.
// a trap and a load in one cycle: the trap wins and the load is
// dropped, so the assembler must present it again if still wanted.
module storage_map
    import store_map_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire sys_size_t   sys_size,
    input  wire logic [15:0] next_addr,
    input  wire logic        addr_load,
    input  wire logic        aux_access,
    input  wire trap_req_t   trap_req,
    output logic [15:0]      storage_address_latch,
    output decode_t          dec,
    output logic             trap_taken,
    output logic [3:0]       aux_module_count
);

    // where the next latch value comes from
    typedef enum logic [1:0] {
        SRC_HOLD,
        SRC_LOAD,
        SRC_TRAP
    } src_t;

    logic [15:0] addr_r;
    logic [15:0] addr_nxt;
    logic        taken_r;
    logic        taken_nxt;
    decode_t     dec_r;
    decode_t     dec_nxt;
    logic [15:0] ctrl_base;
    logic [15:0] prog_top;
    logic        trap_hit;
    logic [15:0] trap_vec;
    logic [3:0]  aux_mod;
    logic [15:0] ctrl_top;
    logic        hole_on;
    logic        in_prog;
    logic        in_ctrl;
    logic        in_hole;
    logic [15:0] aux_present;
    src_t        src;

    // capacity sets the control base and top of program storage
    always_comb begin
        ctrl_base = CTRL_BASE_24_32;
        prog_top  = 16'h7FFF;
        case (sys_size)
            SYS_16K: begin
                ctrl_base = CTRL_BASE_16K;
                prog_top  = CTRL_BASE_16K - 16'h0001;
            end
            SYS_24K: begin
                ctrl_base = CTRL_BASE_24_32;
                prog_top  = HOLE_LO - 16'h0001;
            end
            SYS_32K: begin
                ctrl_base = CTRL_BASE_24_32;
                prog_top  = CTRL_BASE_24_32 - 16'h0001;
            end
            default: begin
                ctrl_base = CTRL_BASE_48K;
                prog_top  = CTRL_BASE_48K - 16'h0001;
            end
        endcase
    end

    trap_vector_gen u_trap (
        .req       (trap_req),
        .ctrl_base (ctrl_base),
        .hit       (trap_hit),
        .vector    (trap_vec)
    );

    // pick the source of the next latch value; a trap beats a load
    always_comb begin
        if (trap_hit) begin
            src = SRC_TRAP;
        end else if (addr_load) begin
            src = SRC_LOAD;
        end else begin
            src = SRC_HOLD;
        end
    end

    // next latch value and trap indication from the chosen source
    always_comb begin
        addr_nxt  = addr_r;
        taken_nxt = 1'b0;
        case (src)
            SRC_TRAP: begin
                // vector goes straight in, bypassing next_addr
                addr_nxt  = trap_vec;
                taken_nxt = 1'b1;
            end
            SRC_LOAD: begin
                addr_nxt = next_addr;
            end
            default: begin
                addr_nxt = addr_r;                    // hold between accesses
            end
        endcase
    end

    // aux module: first digit gives module, digits three and four the byte
    always_comb begin
        aux_mod = addr_nxt[AUX_D1_MSB -: 4];
        case (sys_size)
            SYS_16K: aux_module_count = 4'd7;
            SYS_24K: aux_module_count = 4'd11;        // 8-B stand in for 6-7
            SYS_32K: aux_module_count = 4'd11;
            default: aux_module_count = 4'd15;
        endcase
    end

    // modules present: everything up to the count, less the 24K gap;
    // a mask keeps the decode one lookup instead of a compare chain
    always_comb begin
        aux_present = '0;
        for (int m = 0; m < 16; m++) begin
            aux_present[m] = (4'(m) <= aux_module_count);
        end
        if (sys_size == SYS_24K) begin
            // 24K machines have no modules 6 and 7
            aux_present[6] = 1'b0;
            aux_present[7] = 1'b0;
        end
    end

    // upper end of control storage and whether the 24K hole applies
    always_comb begin
        ctrl_top = 16'(ctrl_base + (CTRL_SIZE - 16'h0001));
        hole_on  = (sys_size == SYS_24K);
    end

    // range tests on the address being latched; for a legal size no range,
    // the hole included, overlaps another, so the order below is harmless
    always_comb begin
        in_prog = (addr_nxt >= PROG_BASE) && (addr_nxt <= prog_top);
        in_ctrl = (addr_nxt >= ctrl_base) && (addr_nxt <= ctrl_top);
        in_hole = hole_on && (addr_nxt >= HOLE_LO) && (addr_nxt <= HOLE_HI);
    end

    // region decode of the address being latched
    always_comb begin
        dec_nxt          = '0;
        dec_nxt.phys     = addr_nxt;
        dec_nxt.aux_addr = {aux_mod, addr_nxt[AUX_D34_MSB -: 8]};
        if (aux_access) begin
            // missing modules answer as unmapped, never alias
            dec_nxt.unmapped = ~aux_present[aux_mod];
        end else if (in_hole) begin
            dec_nxt.unmapped = 1'b1;
        end else if (in_ctrl) begin
            dec_nxt.ctrl_sel = 1'b1;
        end else if (in_prog) begin
            dec_nxt.prog_sel = 1'b1;
        end else begin
            // above control storage on 16K, 24K and 32K
            dec_nxt.unmapped = 1'b1;
        end
    end

    // register stage: address, decode and trap indication
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_r  <= 16'h0000;
            taken_r <= 1'b0;
            dec_r   <= '0;
        end else begin
            addr_r  <= addr_nxt;
            taken_r <= taken_nxt;
            dec_r   <= dec_nxt;
        end
    end

    assign storage_address_latch = addr_r;
    assign dec                   = dec_r;
    assign trap_taken            = taken_r;

endmodule : storage_map

// ===== logic/store_map_pkg.sv
// package: storage map constants, trap offsets and carrier structs
package store_map_pkg;

    localparam int          ADDR_W          = 16;
    localparam int          AUX_W           = 12;
    // control storage is always 16K bytes long, at the top of the map only on 48K
    localparam logic [15:0] CTRL_SIZE       = 16'h4000;
    localparam logic [15:0] PROG_BASE       = 16'h0000;
    // control storage base per system size
    localparam logic [15:0] CTRL_BASE_16K   = 16'h4000;
    localparam logic [15:0] CTRL_BASE_24_32 = 16'h8000;
    localparam logic [15:0] CTRL_BASE_48K   = 16'hC000;
    // hole in the 24K array
    localparam logic [15:0] HOLE_LO         = 16'h6000;
    localparam logic [15:0] HOLE_HI         = 16'h7FFF;
    // trap offsets relative to control storage location zero
    localparam logic [15:0] TRAP_OFS_CSL    = 16'h0010;
    localparam logic [15:0] TRAP_OFS_RESET  = 16'h0240;
    localparam logic [15:0] TRAP_OFS_MCHK   = 16'h0220;
    localparam logic [15:0] TRAP_OFS_MAINT  = 16'h0280;
    localparam logic [15:0] TRAP_OFS_WRAP   = 16'h0210;
    localparam logic [15:0] TRAP_OFS_CHAN   = 16'h0170;
    localparam int          TRAP_N          = 6;
    // aux module digit positions within the address latch
    localparam int          AUX_D1_MSB      = 15;
    localparam int          AUX_D34_MSB     = 7;

    typedef enum logic [1:0] {
        SYS_16K,
        SYS_24K,
        SYS_32K,
        SYS_48K
    } sys_size_t;

    // trap request bits, highest priority first in the vector
    typedef struct packed {
        logic reset_load;
        logic machine_check;
        logic wrap_protect;
        logic chan_priority;
        logic maintenance;
        logic control_store_load_trap;
    } trap_req_t;

    typedef struct packed {
        logic        prog_sel;
        logic        ctrl_sel;
        logic        unmapped;
        logic [15:0] phys;
        logic [11:0] aux_addr;
    } decode_t;

endpackage : store_map_pkg

// ===== logic/trap_vector_gen.sv
// trap vector generator: picks the winning trap and forms its address
module trap_vector_gen
    import store_map_pkg::*;
(
    input  wire trap_req_t   req,
    input  wire logic [15:0] ctrl_base,
    output logic             hit,
    output logic [15:0]      vector
);

    logic [15:0] ofs;

    // fixed priority; each cause owns a distinct offset
    always_comb begin
        hit = 1'b1;
        ofs = TRAP_OFS_CSL;
        if (req.reset_load) begin
            ofs = TRAP_OFS_RESET;
        end else if (req.machine_check) begin
            ofs = TRAP_OFS_MCHK;
        end else if (req.wrap_protect) begin
            ofs = TRAP_OFS_WRAP;
        end else if (req.chan_priority) begin
            ofs = TRAP_OFS_CHAN;
        end else if (req.maintenance) begin
            ofs = TRAP_OFS_MAINT;
        end else if (req.control_store_load_trap) begin
            ofs = TRAP_OFS_CSL;
        end else begin
            hit = 1'b0;
        end
        vector = ctrl_base + ofs;
    end

endmodule : trap_vector_gen

// ===== verif/storage_map_sva.sv
// checker: port relations of the storage map
module storage_map_sva
    import store_map_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire sys_size_t   sys_size,
    input wire logic [15:0] next_addr,
    input wire logic        addr_load,
    input wire logic        aux_access,
    input wire trap_req_t   trap_req,
    input wire logic [15:0] storage_address_latch,
    input wire decode_t     dec,
    input wire logic [3:0]  aux_module_count
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [15:0] base;
    logic [11:0] aux_exp;
    // size may change with the trap clearing, so vectors use the sampled base
    assign base = sys_size == SYS_16K ? CTRL_BASE_16K :
                  sys_size == SYS_48K ? CTRL_BASE_48K : CTRL_BASE_24_32;
    assign aux_exp = {next_addr[15:12], next_addr[7:0]};
    sequence s_go;
        !(|trap_req) && addr_load;
    endsequence
    sequence s_ld;
        s_go ##0 !aux_access;
    endsequence
    a_low_prog: assert property (s_ld ##0 next_addr < 16'h4000 |=> dec.prog_sel)
        else $error("program select");
    a_top_ctrl:
        assert property (s_ld ##0 next_addr[15:14] == base[15:14] |=> dec.ctrl_sel)
        else $error("control select");
    a_hole_24k:
        assert property (s_ld ##0 sys_size == SYS_24K && next_addr[15:13] == 3'h3 |=> dec.unmapped)
        else $error("hole selected");
    a_csl_vec:
        assert property (trap_req == 6'h01 |=> storage_address_latch == $past(base) + TRAP_OFS_CSL)
        else $error("load trap vector");
    a_rst_vec:
        assert property (trap_req.reset_load |=> storage_address_latch == $past(base) + TRAP_OFS_RESET)
        else $error("reset trap vector");
    a_load_path: assert property (s_go |=> storage_address_latch == $past(next_addr))
        else $error("load path");
    a_aux_count: assert property (sys_size == SYS_48K |-> aux_module_count == 4'hF)
        else $error("aux count");
    a_aux_digits: assert property (s_go ##0 aux_access |=> dec.aux_addr == $past(aux_exp))
        else $error("aux digits");
endmodule : storage_map_sva

// ===== verif/addr_assembler.sv
// partner: address assembler feeding the next-address source
module addr_assembler (
    input  wire logic        clk,
    input  wire logic [15:0] want,
    input  wire logic        go,
    output logic [15:0]      next_addr = 16'h0000,
    output logic             addr_load = 1'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus shows the inverse so a stale address never passes
    always @(posedge clk) begin
        next_addr <= go ? want : ~next_addr;
        addr_load <= go;
    end
endmodule : addr_assembler

// ===== verif/testbench.sv
// testbench: traps, region decode and aux select
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import store_map_pkg::*;
    logic        clk = 1'h0, rst = 1'h1, go = 1'h0, aux_access = 1'h0, addr_load, trap_taken;
    logic [15:0] want = 16'h0000, next_addr, storage_address_latch;
    logic [3:0]  aux_module_count;
    sys_size_t   sys_size = SYS_16K;
    trap_req_t   trap_req = '0;
    decode_t     dec;
    int          errors = 0, n_compared = 0;
    always #12.5 clk = ~clk;
    addr_assembler src (.clk, .want, .go, .next_addr, .addr_load);
    storage_map dut (.clk, .rst, .sys_size, .next_addr, .addr_load, .aux_access, .trap_req,
                     .storage_address_latch, .dec, .trap_taken, .aux_module_count);
    task chk(input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // latch answers on the second edge, one after the assembler
    task load(input logic [15:0] a);
        want = a;
        go = 1'h1;
        @(posedge clk) #1 go = 1'h0;
        @(posedge clk) #1;
    endtask : load
    // every cause at every size, back to back
    task t_trap;
        logic [15:0] ofs[6] = '{16'h0240, 16'h0220, 16'h0210, 16'h0170, 16'h0280, 16'h0010};
        logic [15:0] bs[4] = '{16'h4000, 16'h8000, 16'h8000, 16'hC000};
        for (int s = 0; s < 4; s++) begin
            sys_size = sys_size_t'(s);
            for (int i = 0; i < 6; i++) begin
                trap_req = trap_req_t'(6'h20 >> i);
                @(posedge clk) #1 trap_req = '0;
                chk(32'(storage_address_latch), 32'(bs[s] + ofs[i]));
                chk(32'(trap_taken), 32'h1);
            end
        end
    endtask : t_trap
    // selects sit in the top three bits of dec, above the address
    task t_map;
        logic [20:0] map[5] = '{{SYS_16K, 3'h4, 16'h0000}, {SYS_16K, 3'h1, 16'h8000},
            {SYS_24K, 3'h1, 16'h6000}, {SYS_24K, 3'h2, 16'hBFFF}, {SYS_48K, 3'h2, 16'hC000}};
        foreach (map[i]) begin
            sys_size = sys_size_t'(map[i][20:19]);
            load(map[i][15:0]);
            chk(32'(dec[30:12]), 32'(map[i][18:0]));
        end
    endtask : t_map
    // second nibble ignored; a trap beats a load in the same cycle
    task t_aux;
        sys_size = SYS_32K;
        aux_access = 1'h1;
        load(16'h1F34);
        chk(32'(dec.aux_addr), 32'h134);
        chk(32'(aux_module_count), 32'hB);
        sys_size = SYS_24K;
        load(16'h6A00);
        chk(32'(dec.unmapped), 32'h1);
        chk(32'(aux_module_count), 32'hB);
        sys_size = SYS_32K;
        aux_access = 1'h0;
        want = 16'h0100;
        go = 1'h1;
        @(posedge clk) #1 go = 1'h0;
        trap_req.control_store_load_trap = 1'h1;
        @(posedge clk) #1 trap_req = '0;
        chk(32'(storage_address_latch), 32'h8010);
    endtask : t_aux
    task report_and_stop;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (3) @(posedge clk);
        #1 rst = 1'h0;
        t_trap;
        t_map;
        t_aux;
        report_and_stop;
    end
endmodule : testbench
bind storage_map storage_map_sva sva (.clk, .rst, .sys_size, .next_addr, .addr_load,
    .aux_access, .trap_req, .storage_address_latch, .dec, .aux_module_count);
